// ---- rtl/fstc_top.v ----
// Purpose: Moves the supply state machine into safe shutdown on faults.
// Assumes: Fault detectors are asynchronous levels, high while a fault is
//          present; state requests and init results come from same-clock logic.
// Notes:   Entry into startup and exit from safe shutdown are simplified.
`timescale 1ns/100ps
`default_nettype none
`include "fstc_consts.vh"
module fstc_top #(
  parameter [`FSTC_TIMER_W-1:0] GROUND_FAULT_CYCLES = `FSTC_GROUND_FAULT_CYCLES,
  parameter [`FSTC_TIMER_W-1:0] SS2_DELAY_CYCLES    = `FSTC_SS2_DELAY_CYCLES,
  parameter [`FSTC_TIMER_W-1:0] OT_DWELL_CYCLES     = `FSTC_OT_DWELL_CYCLES
) (
  input  wire       CLOCK_I,
  input  wire       RST_I,
  input  wire       PRE_REGULATOR_RAIL_OV_I,
  input  wire       MAIN_MICRO_RAIL_OV_I,
  input  wire       STANDBY_RAIL_OV_I,
  input  wire       COMM_RAIL_OV_I,
  input  wire       REFERENCE_RAIL_OV_I,
  input  wire       MAIN_MICRO_RAIL_UV_I,
  input  wire       STANDBY_RAIL_UV_I,
  input  wire       COMM_RAIL_UV_I,
  input  wire       OVER_TEMPERATURE_TRIP_I,
  input  wire       BIAS_MONITOR_FAIL_I,
  input  wire       SUPPLY_OV_I,
  input  wire       INIT_FAIL_I,
  input  wire       INIT_OK_I,
  input  wire       REQ_NORMAL_I,
  input  wire       REQ_STANDBY_I,
  input  wire       REQ_SLEEP_I,
  input  wire       REQ_WAKE_I,
  input  wire       REQ_EXIT_SAFE_I,
  output wire       RESET_OUTPUT_N_O,
  output wire       PRIMARY_SAFE_STATE_OUT_O,
  output wire       SECONDARY_SAFE_STATE_OUT_O,
  output wire       REGULATORS_ON_O,
  output wire       GROUND_FAULT_O,
  output wire [5:0] STATE_O
);
  localparam [5:0] ST_STARTUP = `FSTC_ST_STARTUP;
  localparam [5:0] ST_NORMAL  = `FSTC_ST_NORMAL;
  localparam [5:0] ST_STANDBY = `FSTC_ST_STANDBY;
  localparam [5:0] ST_SLEEP   = `FSTC_ST_SLEEP;
  localparam [5:0] ST_WAKE    = `FSTC_ST_WAKE;
  localparam [5:0] ST_SAFE    = `FSTC_ST_SAFE;

  wire [10:0] pins_async;
  wire [10:0] pins;
  wire        prereg_ov;
  wire        micro_ov;
  wire        stby_ov;
  wire        comm_ov;
  wire        ref_ov;
  wire        micro_uv;
  wire        stby_uv;
  wire        comm_uv;
  wire        over_temp;
  wire        bias_fail;
  wire        supply_ov;

  reg  [5:0]  state_reg;
  reg  [5:0]  state_next;
  reg         reset_n_reg;
  reg         reset_n_next;
  reg         ss1_reg;
  reg         ss1_next;
  reg         ss2_reg;
  reg         ss2_next;
  reg         reg_on_reg;
  reg         reg_on_next;
  reg         gf_reg;
  reg         gf_next;
  reg         ot_dwell_reg;
  reg         ot_dwell_next;
  reg  [1:0]  init_fail_reg;
  reg  [1:0]  init_fail_next;

  wire        any_uv;
  wire        rail_ov;
  wire        init_fail3;
  wire        gf_done;
  wire        ss2_done;
  wire        dwell_done;
  wire        st_startup;
  wire        st_standby;
  wire        st_safe;
  wire        fail_common;
  wire        safe_trig;
  wire        uv_trig;

  assign pins_async = {PRE_REGULATOR_RAIL_OV_I, MAIN_MICRO_RAIL_OV_I,
                       STANDBY_RAIL_OV_I, COMM_RAIL_OV_I, REFERENCE_RAIL_OV_I,
                       MAIN_MICRO_RAIL_UV_I, STANDBY_RAIL_UV_I, COMM_RAIL_UV_I,
                       OVER_TEMPERATURE_TRIP_I, BIAS_MONITOR_FAIL_I,
                       SUPPLY_OV_I};

  fstc_sync #(
    .W (11)
  ) u_sync (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .d_i   (pins_async),
    .q_o   (pins)
  );

  assign prereg_ov = pins[10];
  assign micro_ov  = pins[9];
  assign stby_ov   = pins[8];
  assign comm_ov   = pins[7];
  assign ref_ov    = pins[6];
  assign micro_uv  = pins[5];
  assign stby_uv   = pins[4];
  assign comm_uv   = pins[3];
  assign over_temp = pins[2];
  assign bias_fail = pins[1];
  assign supply_ov = pins[0];

  assign st_startup = state_reg[0];
  assign st_standby = state_reg[2];
  assign st_safe    = state_reg[5];

  assign any_uv  = micro_uv | stby_uv | comm_uv;
  assign rail_ov = prereg_ov | micro_ov | stby_ov | comm_ov | ref_ov;

  // An undervoltage that outlasts the fault time is taken as a short to ground.
  fstc_timer #(
    .W     (`FSTC_TIMER_W),
    .LIMIT (GROUND_FAULT_CYCLES)
  ) u_gf_timer (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .run_i  (any_uv & ~st_safe),
    .done_o (gf_done)
  );

  // Delayed drop of the secondary safe output after leaving normal for startup.
  fstc_timer #(
    .W     (`FSTC_TIMER_W),
    .LIMIT (SS2_DELAY_CYCLES)
  ) u_ss2_timer (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .run_i  (st_startup & ss2_reg),
    .done_o (ss2_done)
  );

  // Minimum stay in safe shutdown after an over temperature trip.
  fstc_timer #(
    .W     (`FSTC_TIMER_W),
    .LIMIT (OT_DWELL_CYCLES)
  ) u_dwell_timer (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .run_i  (st_safe & ot_dwell_reg),
    .done_o (dwell_done)
  );

  assign init_fail3 = (init_fail_reg == `FSTC_INIT_FAIL_LIMIT);

  assign fail_common = over_temp | init_fail3 | gf_done | bias_fail
                     | (supply_ov & ~st_standby);

  // Standby watches only its own rail; every other state but safe shutdown sees all rails.
  assign safe_trig = ~st_safe & (fail_common
                   | (st_standby ? stby_ov : rail_ov));

  assign uv_trig = any_uv & ~st_safe & ~st_startup;

  always @* begin
    init_fail_next = init_fail_reg;
    if (st_safe && REQ_EXIT_SAFE_I) begin
      // A failure reported in the clearing cycle still counts.
      init_fail_next = {1'b0, INIT_FAIL_I};
    end else if (INIT_OK_I) begin
      init_fail_next = 2'h0;
    end else if (INIT_FAIL_I && !init_fail3) begin
      init_fail_next = init_fail_reg + 2'h1;
    end
  end

  always @* begin
    state_next    = state_reg;
    ot_dwell_next = ot_dwell_reg;
    case (state_reg)
      ST_STARTUP: begin
        if (REQ_NORMAL_I && !any_uv) begin
          state_next = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (REQ_STANDBY_I) begin
          state_next = ST_STANDBY;
        end else if (REQ_SLEEP_I) begin
          state_next = ST_SLEEP;
        end
      end
      ST_STANDBY: begin
        if (REQ_WAKE_I) begin
          state_next = ST_WAKE;
        end
      end
      ST_SLEEP: begin
        if (REQ_WAKE_I) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (REQ_NORMAL_I) begin
          state_next = ST_NORMAL;
        end
      end
      ST_SAFE: begin
        if (REQ_EXIT_SAFE_I && !over_temp && (!ot_dwell_reg || dwell_done)) begin
          state_next    = ST_STARTUP;
          ot_dwell_next = 1'b0;
        end
      end
      default: begin
        state_next = ST_SAFE;
      end
    endcase
    // Safe shutdown is checked last so that it overrides a startup entry.
    if (uv_trig) begin
      state_next = ST_STARTUP;
    end
    if (safe_trig) begin
      state_next = ST_SAFE;
      if (over_temp) begin
        ot_dwell_next = 1'b1;
      end
    end
  end

  always @* begin
    // Reset is released only in normal, sleep, wake or a healthy startup.
    reset_n_next = 1'b0;
    case (state_next)
      ST_NORMAL: begin
        reset_n_next = 1'b1;
      end
      ST_SLEEP: begin
        reset_n_next = 1'b1;
      end
      ST_WAKE: begin
        reset_n_next = 1'b1;
      end
      ST_STARTUP: begin
        reset_n_next = ~any_uv;
      end
      default: begin
        reset_n_next = 1'b0;
      end
    endcase
    ss1_next = (state_next == ST_NORMAL);
    if (state_next == ST_NORMAL) begin
      ss2_next = 1'b1;
    end else if (state_next == ST_STARTUP) begin
      ss2_next = ss2_reg & ~ss2_done;
    end else begin
      ss2_next = 1'b0;
    end
    reg_on_next = (state_next != ST_SAFE);
    gf_next     = gf_reg | gf_done;
    if (st_safe && REQ_EXIT_SAFE_I && (state_next == ST_STARTUP)) begin
      gf_next = gf_done;
    end
  end

  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg     <= ST_STARTUP;
      reset_n_reg   <= 1'b0;
      ss1_reg       <= 1'b0;
      ss2_reg       <= 1'b0;
      reg_on_reg    <= 1'b1;
      gf_reg        <= 1'b0;
      ot_dwell_reg  <= 1'b0;
      init_fail_reg <= 2'h0;
    end else begin
      state_reg     <= state_next;
      reset_n_reg   <= reset_n_next;
      ss1_reg       <= ss1_next;
      ss2_reg       <= ss2_next;
      reg_on_reg    <= reg_on_next;
      gf_reg        <= gf_next;
      ot_dwell_reg  <= ot_dwell_next;
      init_fail_reg <= init_fail_next;
    end
  end

  assign RESET_OUTPUT_N_O           = reset_n_reg;
  assign PRIMARY_SAFE_STATE_OUT_O   = ss1_reg;
  assign SECONDARY_SAFE_STATE_OUT_O = ss2_reg;
  assign REGULATORS_ON_O            = reg_on_reg;
  assign GROUND_FAULT_O             = gf_reg;
  assign STATE_O                    = state_reg;
endmodule
`default_nettype wire

// ---- inc/fstc_consts.vh ----
// Purpose: Constants for the fault-driven safe shutdown transition block.
// Assumes: A 10 MHz core clock.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef FSTC_CONSTS_VH
`define FSTC_CONSTS_VH

`define FSTC_CLK_HZ              10000000
`define FSTC_GROUND_FAULT_TIME_US 1000
`define FSTC_SS2_DELAY_TIME_US    100
`define FSTC_OT_DWELL_TIME_S      1

// Least times round up to whole cycles.
`define FSTC_GROUND_FAULT_CYCLES \
  ((`FSTC_GROUND_FAULT_TIME_US * (`FSTC_CLK_HZ / 1000) + 999) / 1000)
`define FSTC_SS2_DELAY_CYCLES \
  ((`FSTC_SS2_DELAY_TIME_US * (`FSTC_CLK_HZ / 1000) + 999) / 1000)
`define FSTC_OT_DWELL_CYCLES     (`FSTC_OT_DWELL_TIME_S * `FSTC_CLK_HZ)

`define FSTC_TIMER_W             24
`define FSTC_INIT_FAIL_LIMIT     2'h3

`define FSTC_ST_STARTUP          6'h01
`define FSTC_ST_NORMAL           6'h02
`define FSTC_ST_STANDBY          6'h04
`define FSTC_ST_SLEEP            6'h08
`define FSTC_ST_WAKE             6'h10
`define FSTC_ST_SAFE             6'h20

`endif

// ---- rtl/fstc_sync.v ----
// Purpose: Two-stage synchroniser for asynchronous fault detector levels.
// Assumes: Inputs are slow levels; no pulse shorter than two cycles matters.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module fstc_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d_i[gi];
          sync_reg <= meta_reg;
        end
      end
      assign q_o[gi] = sync_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// ---- rtl/fstc_timer.v ----
// Purpose: Saturating elapsed-time counter with a done flag.
// Assumes: LIMIT is at least one.
// Notes:   Counting restarts from zero whenever run_i falls.
`timescale 1ns/100ps
`default_nettype none
module fstc_timer #(
  parameter         W     = 24,
  parameter [W-1:0] LIMIT = 1
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire run_i,
  output wire done_o
);
  reg [W-1:0] cnt_reg;
  reg [W-1:0] cnt_next;

  always @* begin
    if (!run_i) begin
      cnt_next = {W{1'b0}};
    end else if (cnt_reg < LIMIT) begin
      cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= {W{1'b0}};
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done_o = run_i && (cnt_reg >= LIMIT);
endmodule
`default_nettype wire

// ---- dv/fstc_monitor.sv ----
// Purpose: Temporal checks on the safe shutdown outputs of the block.
// Assumes: One clock; RST_I is asynchronous and active high.
// Notes:   Pin faults show at the outputs three edges after first sampling.
`timescale 1ns/100ps
`default_nettype none
module fstc_monitor #(
  parameter int OT_DWELL_CYCLES = 20
) (
  input wire logic       CLOCK_I,
  input wire logic       RST_I,
  input wire logic       PRE_REGULATOR_RAIL_OV_I,
  input wire logic       MAIN_MICRO_RAIL_UV_I,
  input wire logic       OVER_TEMPERATURE_TRIP_I,
  input wire logic       RESET_OUTPUT_N_O,
  input wire logic       PRIMARY_SAFE_STATE_OUT_O,
  input wire logic       SECONDARY_SAFE_STATE_OUT_O,
  input wire logic       REGULATORS_ON_O,
  input wire logic       GROUND_FAULT_O,
  input wire logic [5:0] STATE_O
);
  logic        safe;
  logic [31:0] dwell_reg;
  logic        hot_reg;
  logic        safe_d_reg;
  logic [2:0]  ot_pipe_reg;
  assign safe = (STATE_O == 6'h20);
  // Counts cycles in safe shutdown and remembers an entry that an over
  // temperature caused; the pin history covers the synchroniser delay.
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      dwell_reg   <= 32'h0;
      hot_reg     <= 1'b0;
      safe_d_reg  <= 1'b0;
      ot_pipe_reg <= 3'h0;
    end else begin
      dwell_reg   <= safe ? dwell_reg + 32'h1 : 32'h0;
      hot_reg     <= safe & (hot_reg | (!safe_d_reg & (|ot_pipe_reg)));
      safe_d_reg  <= safe;
      ot_pipe_reg <= {ot_pipe_reg[1:0], OVER_TEMPERATURE_TRIP_I};
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  a_safe_regs_off: assert property (safe |-> !REGULATORS_ON_O)
    else $error("regulators on in safe shutdown");
  a_safe_reset_low: assert property (safe |-> !RESET_OUTPUT_N_O)
    else $error("reset released in safe shutdown");
  a_safe_outs_low: assert property (safe |-> !PRIMARY_SAFE_STATE_OUT_O
    && !SECONDARY_SAFE_STATE_OUT_O) else $error("safe output high in safe shutdown");
  a_startup_pri_low: assert property (STATE_O == 6'h01 |-> !PRIMARY_SAFE_STATE_OUT_O)
    else $error("primary safe output high in startup");
  a_ov_to_safe: assert property ((PRE_REGULATOR_RAIL_OV_I && STATE_O != 6'h04)[*3]
    |-> ##[1:2] safe) else $error("overvoltage did not reach safe shutdown");
  a_ot_to_safe: assert property (OVER_TEMPERATURE_TRIP_I[*3] |-> ##[1:2] safe)
    else $error("over temperature did not reach safe shutdown");
  a_uv_to_startup: assert property ((MAIN_MICRO_RAIL_UV_I && !PRE_REGULATOR_RAIL_OV_I
    && STATE_O == 6'h02)[*3] |-> ##1 (STATE_O == 6'h01 && !RESET_OUTPUT_N_O
    && !PRIMARY_SAFE_STATE_OUT_O && SECONDARY_SAFE_STATE_OUT_O))
    else $error("undervoltage did not reach startup correctly");
  a_gf_trip_off: assert property ($rose(GROUND_FAULT_O) |-> safe && !REGULATORS_ON_O)
    else $error("ground fault without safe shutdown");
  a_hot_dwell: assert property (!safe && hot_reg |-> dwell_reg >= OT_DWELL_CYCLES)
    else $error("left safe shutdown before dwell time");
endmodule
bind fstc_top fstc_monitor #(.OT_DWELL_CYCLES(OT_DWELL_CYCLES)) u_mon (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .PRE_REGULATOR_RAIL_OV_I(PRE_REGULATOR_RAIL_OV_I),
  .MAIN_MICRO_RAIL_UV_I(MAIN_MICRO_RAIL_UV_I), .OVER_TEMPERATURE_TRIP_I(OVER_TEMPERATURE_TRIP_I),
  .RESET_OUTPUT_N_O(RESET_OUTPUT_N_O), .PRIMARY_SAFE_STATE_OUT_O(PRIMARY_SAFE_STATE_OUT_O),
  .SECONDARY_SAFE_STATE_OUT_O(SECONDARY_SAFE_STATE_OUT_O), .REGULATORS_ON_O(REGULATORS_ON_O),
  .GROUND_FAULT_O(GROUND_FAULT_O), .STATE_O(STATE_O));
`default_nettype wire

// ---- dv/fstc_micro.sv ----
// Purpose: Microcontroller model issuing state requests to the block.
// Assumes: Requests are one-cycle levels launched on a rising edge.
// Notes:   Command 1 normal, 2 standby, 3 sleep, 4 wake; 0 is idle.
`timescale 1ns/100ps
`default_nettype none
module fstc_micro (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] cmd_i,
  output logic      [3:0] req_o
);
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_o <= 4'h0;
    end else begin
      req_o <= (cmd_i == 3'h0) ? 4'h0 : 4'h1 << (cmd_i - 3'h1);
    end
  end
endmodule
`default_nettype wire

// ---- dv/safe_shutdown_state_transition_control_bench.sv ----
// Purpose: Self-checking bench for the safe shutdown transition block.
// Assumes: 10 MHz clock; inputs change 10 ns after each rising edge.
// Notes:   Shortened counts keep the run to a few hundred cycles.
`timescale 1ns/100ps
`default_nettype none
module safe_shutdown_state_transition_control_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [10:0] flt = 11'h0;
  logic        init_fail = 1'b0;
  logic        init_ok = 1'b0;
  logic        exit_req = 1'b0;
  logic [2:0]  cmd = 3'h0;
  logic [3:0]  req;
  wire         rst_n, pri, sec, regs, gf;
  wire  [5:0]  st;
  wire  [7:0]  so = {2'h0, st};
  wire  [7:0]  outs = {3'h0, gf, rst_n, pri, sec, regs};
  int          failures = 0;
  int          checks = 0;
  // Row: start state, fault pin, expected state, expected outputs.
  logic [23:0] rows [21] = '{24'h010200, 24'h019200, 24'h01a200, 24'h020200,
    24'h021200, 24'h022200, 24'h023200, 24'h024200, 24'h028200, 24'h02a200,
    24'h042200, 24'h049200, 24'h048200, 24'h04a041, 24'h080200, 24'h081200,
    24'h103200, 24'h104200, 24'h108200, 24'h026013, 24'h087011};
  always #50 clk = ~clk;
  fstc_top #(.GROUND_FAULT_CYCLES(24'h8), .SS2_DELAY_CYCLES(24'hc),
    .OT_DWELL_CYCLES(24'h14)) i_dut (.CLOCK_I(clk), .RST_I(rst),
    .PRE_REGULATOR_RAIL_OV_I(flt[0]), .MAIN_MICRO_RAIL_OV_I(flt[1]),
    .STANDBY_RAIL_OV_I(flt[2]), .COMM_RAIL_OV_I(flt[3]), .REFERENCE_RAIL_OV_I(flt[4]),
    .MAIN_MICRO_RAIL_UV_I(flt[5]), .STANDBY_RAIL_UV_I(flt[6]), .COMM_RAIL_UV_I(flt[7]),
    .OVER_TEMPERATURE_TRIP_I(flt[8]), .BIAS_MONITOR_FAIL_I(flt[9]), .SUPPLY_OV_I(flt[10]),
    .INIT_FAIL_I(init_fail), .INIT_OK_I(init_ok), .REQ_NORMAL_I(req[0]),
    .REQ_STANDBY_I(req[1]), .REQ_SLEEP_I(req[2]), .REQ_WAKE_I(req[3]),
    .REQ_EXIT_SAFE_I(exit_req), .RESET_OUTPUT_N_O(rst_n), .PRIMARY_SAFE_STATE_OUT_O(pri),
    .SECONDARY_SAFE_STATE_OUT_O(sec), .REGULATORS_ON_O(regs), .GROUND_FAULT_O(gf),
    .STATE_O(st));
  fstc_micro i_mcu (.clk_i(clk), .rst_i(rst), .cmd_i(cmd), .req_o(req));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_st(input logic [5:0] s);
    int n;
    for (n = 0; n < 40 && st !== s; n++) cyc(1);
    chk(so, {2'h0, s});
    if (st !== s) complete_run();
  endtask
  task automatic do_reset(input int n);
    flt = 11'h0;
    rst = 1'b1;
    cyc(n);
    rst = 1'b0;
  endtask
  task automatic send(input logic [2:0] c);
    cmd = c;
    cyc(1);
    cmd = 3'h0;
    cyc(3);
  endtask
  task automatic go(input logic [7:0] s);
    if (s != 8'h01) send(3'h1);
    if (s == 8'h04) send(3'h2);
    if (s == 8'h08 || s == 8'h10) send(3'h3);
    if (s == 8'h10) send(3'h4);
  endtask
  task automatic pulse(input logic ok);
    {init_ok, init_fail} = ok ? 2'h2 : 2'h1;
    cyc(1);
    {init_ok, init_fail} = 2'h0;
    cyc(1);
  endtask
  initial begin
    int n;
    logic saw;
    cyc(10);
    chk(so, 8'h01);
    chk(outs, 8'h01);
    rst = 1'b0;
    cyc(1);
    chk(outs, 8'h09);
    foreach (rows[i]) begin
      do_reset(2);
      go(rows[i][23:16]);
      flt[rows[i][15:12]] = 1'b1;
      cyc(5);
      chk(so, rows[i][11:4]);
      chk(outs, {4'h0, rows[i][3:0]});
    end
    do_reset(2);
    go(8'h02);
    flt[5] = 1'b1;
    wait_st(6'h01);
    cyc(5);
    chk(so, 8'h01);
    chk(outs, 8'h03);
    wait_st(6'h20);
    chk(outs, 8'h10);
    do_reset(2);
    go(8'h02);
    flt = 11'h021;
    saw = 1'b0;
    for (n = 0; n < 6; n++) begin
      cyc(1);
      saw = saw | (st === 6'h01);
    end
    chk({7'h0, saw}, 8'h00);
    chk(so, 8'h20);
    do_reset(2);
    repeat (2) pulse(1'b0);
    pulse(1'b1);
    repeat (2) pulse(1'b0);
    cyc(3);
    chk(so, 8'h01);
    pulse(1'b0);
    wait_st(6'h20);
    do_reset(2);
    go(8'h02);
    flt[8] = 1'b1;
    wait_st(6'h20);
    flt[8] = 1'b0;
    exit_req = 1'b1;
    for (n = 0; n < 60 && st !== 6'h01; n++) cyc(1);
    exit_req = 1'b0;
    chk(so, 8'h01);
    chk({7'h0, n >= 20}, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire
